// ---- rtl/i2ee_consts.svh ----
// Shared constants for the two-wire serial memory and its bus master
`ifndef I2EE_CONSTS_SVH
`define I2EE_CONSTS_SVH

`define I2EE_DEV_CODE      4'hA
`define I2EE_MEM_BYTES     32768
`define I2EE_ADDR_W        15
`define I2EE_PAGE_BYTES    64
`define I2EE_PAGE_W        9
`define I2EE_OFF_W         6
`define I2EE_ERASED        8'hFF
`define I2EE_CLK_MHZ       25
`define I2EE_WR_TIME_NS    5000000
`define I2EE_WR_CYCLES     ((`I2EE_WR_TIME_NS * `I2EE_CLK_MHZ) / 1000)
`define I2EE_SCL_PERIOD_NS 320
`define I2EE_QTR_CYCLES    ((`I2EE_SCL_PERIOD_NS * `I2EE_CLK_MHZ) / 4000)
`define I2EE_FIFO_DEPTH    16

`endif

// ---- rtl/i2ee_dev.sv ----
// Serial memory slave end: address decode, page buffer, programming, reads
`timescale 1ns/1ps
`include "i2ee_consts.svh"

// Function
// - Slave address top nibble must be 1010
// - Next three bits must match strap pins
// - Address LSB: 1 read, 0 write
// - Acknowledge matching address in ninth pulse
// - Acknowledge both address bytes; data only when not write-protected
// - Read: eight bits, release, continue on ack
// - Master ends read with nack, stop
// - Byte write: four acked bytes, stop
// - No address ack while programming runs
// - 32768 bytes as 512 pages of 64
// - Top bit ignored, 9 page, 6 offset
// - Offset wraps within page, overwriting earlier
// - Program up to 64 bytes on stop
// - Write-protect high blocks all writes
// - Protect sampled before first data byte
// - Memory starts with every byte FFh
// - Pointer follows last access, rolls over
// - Read address sends byte at pointer
// - Dummy write loads pointer, no programming
// - Sequential read wraps to zero
// - Start and stop decoded with clock high
// - Sample on rise, drive after fall, low only
module i2ee_dev
  import i2ee_pkg::*;
#(
  parameter int WR_CYCLES = `I2EE_WR_CYCLES
) (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic STRAP_SELECT_BIT0,
  input  wire logic STRAP_SELECT_BIT1,
  input  wire logic STRAP_SELECT_BIT2,
  input  wire logic WP,
  output logic      BUSY,
  i2ee_if.dev       bus
);
  localparam int CW = $clog2(WR_CYCLES + 1);
  // --------------------------------------------------------------
  // Pin synchronisers and bus events
  // --------------------------------------------------------------
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       scl_h;
  logic       sda_v;
  logic [2:0] strap;
  logic       wp_pin;
  logic       start_ev;
  logic       stop_ev;
  logic       rise;
  logic       fall;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_s1_reg <= 6'h3;
      pin_s2_reg <= 6'h3;
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
    end else begin
      pin_s1_reg <= {WP, STRAP_SELECT_BIT2, STRAP_SELECT_BIT1, STRAP_SELECT_BIT0,
                     bus.scl, bus.sda};
      pin_s2_reg <= pin_s1_reg;
      scl_d_reg  <= pin_s2_reg[1];
      sda_d_reg  <= pin_s2_reg[0];
    end
  end
  assign scl_h    = pin_s2_reg[1];
  assign sda_v    = pin_s2_reg[0];
  assign strap    = pin_s2_reg[4:2];
  assign wp_pin   = pin_s2_reg[5];
  assign start_ev = scl_h & scl_d_reg & sda_d_reg & ~sda_v;
  assign stop_ev  = scl_h & scl_d_reg & ~sda_d_reg & sda_v;
  assign rise     = scl_h & ~scl_d_reg;
  assign fall     = ~scl_h & scl_d_reg;
  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [7:0]                   mem [0:`I2EE_MEM_BYTES-1];
  logic [7:0]                   pbuf [0:`I2EE_PAGE_BYTES-1];
  logic [`I2EE_PAGE_BYTES-1:0]  pvalid_reg;
  logic [`I2EE_ADDR_W-1:0]      ptr_reg;
  logic [`I2EE_PAGE_W-1:0]      page_reg;
  logic [`I2EE_OFF_W-1:0]       off_reg;
  logic                         busy_reg;
  logic [CW-1:0]                bcnt_reg;
  logic [`I2EE_OFF_W-1:0]       pidx;
  logic                         launch;
  logic                         prog_done;
  // Erased array at power-up; the array itself carries no reset
  initial begin
    for (int i = 0; i < `I2EE_MEM_BYTES; i++) begin
      mem[i] = `I2EE_ERASED;
    end
  end
  // --------------------------------------------------------------
  // Protocol engine
  // --------------------------------------------------------------
  i2ee_phase_t phase_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [6:0]  ahi_reg;
  logic        oe_reg;
  logic        mack_reg;
  logic        wp_blk_reg;
  logic        addr_match;
  logic        wr_stb;
  logic [7:0]  rd_byte;
  assign addr_match = (shift_reg[7:4] == `I2EE_DEV_CODE)
                    & (shift_reg[3:1] == strap)
                    & ~busy_reg;
  assign wr_stb  = fall & (cnt_reg == 4'h8) & (phase_reg == PH_WDATA) & ~wp_blk_reg;
  assign rd_byte = mem[ptr_reg];
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_reg  <= PH_IDLE;
      cnt_reg    <= 4'h0;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      ahi_reg    <= 7'h00;
      oe_reg     <= 1'b0;
      mack_reg   <= 1'b0;
      wp_blk_reg <= 1'b0;
      ptr_reg    <= '0;
      page_reg   <= '0;
      off_reg    <= '0;
    end else if (start_ev) begin
      phase_reg <= PH_DEV;
      cnt_reg   <= 4'h0;
      oe_reg    <= 1'b0;
    end else if (stop_ev) begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= 4'h0;
      oe_reg    <= 1'b0;
    end else if (phase_reg != PH_IDLE && phase_reg != PH_SKIP) begin
      if (rise) begin
        if (cnt_reg < 4'h8) begin
          shift_reg <= {shift_reg[6:0], sda_v};
          cnt_reg   <= cnt_reg + 4'h1;
        end else if (cnt_reg == 4'h8) begin
          mack_reg <= ~sda_v;
          cnt_reg  <= 4'h9;
        end
      end else if (fall) begin
        if (cnt_reg == 4'h8) begin
          case (phase_reg)
            PH_DEV: begin
              if (addr_match) begin
                oe_reg <= 1'b1;
              end else begin
                phase_reg <= PH_SKIP;
              end
            end
            PH_AHI: begin
              ahi_reg <= shift_reg[6:0];
              oe_reg  <= 1'b1;
            end
            PH_ALO: begin
              // Pointer loads here so a repeated start reads from it
              ptr_reg  <= {ahi_reg, shift_reg};
              page_reg <= {ahi_reg, shift_reg[7:6]};
              off_reg  <= shift_reg[5:0];
              oe_reg   <= 1'b1;
            end
            PH_WDATA: begin
              if (wp_blk_reg) begin
                phase_reg <= PH_SKIP;
              end else begin
                oe_reg  <= 1'b1;
                off_reg <= off_reg + 6'h01;
                ptr_reg <= {page_reg, 6'(off_reg + 6'h01)};
              end
            end
            default: begin
              oe_reg <= 1'b0;
            end
          endcase
        end else if (cnt_reg == 4'h9) begin
          cnt_reg <= 4'h0;
          oe_reg  <= 1'b0;
          case (phase_reg)
            PH_DEV: begin
              if (shift_reg[0]) begin
                phase_reg <= PH_RDATA;
                oe_reg    <= ~rd_byte[7];
                tx_reg    <= {rd_byte[6:0], 1'b0};
                ptr_reg   <= ptr_reg + 15'h0001;
              end else begin
                phase_reg <= PH_AHI;
              end
            end
            PH_AHI: begin
              phase_reg <= PH_ALO;
            end
            PH_ALO: begin
              phase_reg  <= PH_WDATA;
              wp_blk_reg <= wp_pin;
            end
            PH_RDATA: begin
              if (mack_reg) begin
                oe_reg  <= ~rd_byte[7];
                tx_reg  <= {rd_byte[6:0], 1'b0};
                ptr_reg <= ptr_reg + 15'h0001;
              end else begin
                phase_reg <= PH_SKIP;
              end
            end
            default: begin
            end
          endcase
        end else if (phase_reg == PH_RDATA && cnt_reg != 4'h0) begin
          oe_reg <= ~tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Page buffer
  // --------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (wr_stb) begin
      pbuf[off_reg] <= shift_reg;
    end
  end
  // A start outside programming drops bytes never closed by a stop
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pvalid_reg <= '0;
    end else if (wr_stb) begin
      pvalid_reg[off_reg] <= 1'b1;
    end else if (prog_done || (start_ev && !busy_reg)) begin
      pvalid_reg <= '0;
    end
  end
  // --------------------------------------------------------------
  // Programming cycle
  // --------------------------------------------------------------
  assign launch    = stop_ev & ~busy_reg & (|pvalid_reg) & (phase_reg == PH_WDATA);
  assign prog_done = busy_reg & (bcnt_reg == CW'(WR_CYCLES - 1));
  assign pidx      = bcnt_reg[`I2EE_OFF_W-1:0];
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      busy_reg <= 1'b0;
      bcnt_reg <= '0;
    end else if (launch) begin
      busy_reg <= 1'b1;
      bcnt_reg <= '0;
    end else if (prog_done) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      bcnt_reg <= bcnt_reg + CW'(1);
    end
  end
  // The first 64 busy cycles copy the buffer, the rest models cell time
  always_ff @(posedge CLK) begin
    if (busy_reg && bcnt_reg < CW'(`I2EE_PAGE_BYTES) && pvalid_reg[pidx] && !wp_blk_reg) begin
      mem[{page_reg, pidx}] <= pbuf[pidx];
    end
  end
  assign BUSY           = busy_reg;
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = oe_reg;
endmodule

// ---- rtl/i2ee_host.sv ----
// Bus master end with its write-data FIFO
`timescale 1ns/1ps
`include "i2ee_consts.svh"

module i2ee_fifo #(
  parameter int W = 8,
  parameter int D = `I2EE_FIFO_DEPTH
) (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  fmem [0:D-1];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = fmem[rp_reg];

  always_ff @(posedge CLK) begin
    if (push) begin
      fmem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wp_reg    <= '0;
      rp_reg    <= '0;
      cnt_reg   <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wp_reg    <= push ? AW'(wp_reg + AW'(1)) : wp_reg;
      rp_reg    <= pop ? AW'(rp_reg + AW'(1)) : rp_reg;
      cnt_reg   <= cnt_next;
      in_ready  <= cnt_next != (AW+1)'(D);
      out_valid <= cnt_next != '0;
    end
  end
endmodule

module i2ee_host
  import i2ee_pkg::*;
#(
  parameter int QTR = `I2EE_QTR_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire logic [1:0]  CMD_OP,
  input  wire logic [2:0]  CMD_DEV,
  input  wire logic [15:0] CMD_ADDR,
  input  wire logic [6:0]  CMD_LEN,
  input  wire logic [7:0]  WR_DATA,
  input  wire logic        WR_VALID,
  output logic             WR_READY,
  output logic [7:0]       RD_DATA,
  output logic             RD_VALID,
  output logic             DONE,
  output logic             NACK,
  i2ee_if.host             bus
);

  // --------------------------------------------------------------
  // Quarter-bit tick and data line sampling
  // --------------------------------------------------------------
  logic [7:0] div_reg;
  logic       tick;
  logic       sda_s1_reg;
  logic       sda_s2_reg;

  assign tick = div_reg == 8'(QTR - 1);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_reg    <= 8'h00;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      div_reg    <= tick ? 8'h00 : div_reg + 8'h01;
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  // --------------------------------------------------------------
  // Transfer sequencer
  // --------------------------------------------------------------
  i2ee_hstate_t st_reg;
  i2ee_step_t   step_reg;
  i2ee_op_t     op_reg;
  logic [1:0]   q_reg;
  logic [3:0]   bit_reg;
  logic [8:0]   out_reg;
  logic [8:0]   in_reg;
  logic [2:0]   dev_reg;
  logic [15:0]  addr_reg;
  logic [6:0]   len_reg;
  logic         scl_reg;
  logic         oe_reg;
  logic         f_valid;
  logic [7:0]   f_data;
  logic         f_pop;
  logic         byte_end;
  logic         ack;

  assign f_pop    = (st_reg == HS_WAIT) & f_valid;
  assign byte_end = tick & (st_reg == HS_BYTE) & (q_reg == 2'h3) & (bit_reg == 4'h8);
  assign ack      = ~sda_s2_reg;

  i2ee_fifo #(.W(8), .D(`I2EE_FIFO_DEPTH)) u_fifo (
    .CLK       (CLK),
    .RST       (RST),
    .in_valid  (WR_VALID),
    .in_ready  (WR_READY),
    .in_data   (WR_DATA),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= HS_IDLE;
      step_reg <= ST_DEV;
      op_reg <= OP_WRITE;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      out_reg <= 9'h1FF;
      in_reg <= 9'h000;
      dev_reg <= 3'h0;
      addr_reg <= 16'h0000;
      len_reg <= 7'h00;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      CMD_READY <= 1'b1;
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
      DONE <= 1'b0;
      NACK <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      DONE     <= 1'b0;
      case (st_reg)
        HS_IDLE: begin
          if (CMD_VALID) begin
            st_reg <= HS_START;
            step_reg <= ST_DEV;
            op_reg <= i2ee_op_t'(CMD_OP);
            dev_reg <= CMD_DEV;
            addr_reg <= CMD_ADDR;
            len_reg <= CMD_LEN;
            CMD_READY <= 1'b0;
            NACK <= 1'b0;
            q_reg <= 2'h0;
          end
        end
        HS_START: begin
          if (tick) begin
            q_reg <= q_reg + 2'h1;
            case (q_reg)
              // Clock low first, so a repeated start lets the device drop its ack
              2'h0: scl_reg <= 1'b0;
              2'h1: oe_reg <= 1'b0;
              2'h2: scl_reg <= 1'b1;
              default: begin
                oe_reg <= 1'b1;
                st_reg <= HS_BYTE;
                bit_reg <= 4'h0;
                out_reg <= {`I2EE_DEV_CODE, dev_reg,
                            (step_reg == ST_DEVR) || (op_reg == OP_CUR_READ), 1'b1};
              end
            endcase
          end
        end
        HS_WAIT: begin
          if (f_valid) begin
            st_reg <= HS_BYTE;
            q_reg <= 2'h0;
            bit_reg <= 4'h0;
            out_reg <= {f_data, 1'b1};
            len_reg <= len_reg - 7'h01;
          end
        end
        HS_BYTE: begin
          if (tick) begin
            q_reg <= q_reg + 2'h1;
            case (q_reg)
              2'h0: scl_reg <= 1'b0;
              2'h1: oe_reg <= ~out_reg[8];
              2'h2: scl_reg <= 1'b1;
              default: begin
                in_reg <= {in_reg[7:0], sda_s2_reg};
                out_reg <= {out_reg[7:0], 1'b1};
                bit_reg <= bit_reg + 4'h1;
              end
            endcase
          end
          if (byte_end) begin
            bit_reg <= 4'h0;
            if (step_reg == ST_RD) begin
              RD_DATA <= in_reg[7:0];
              RD_VALID <= 1'b1;
            end
            if (step_reg != ST_RD && !ack) begin
              NACK <= 1'b1;
              st_reg <= HS_STOP;
            end else begin
              case (step_reg)
                ST_DEV: begin
                  step_reg <= (op_reg == OP_CUR_READ) ? ST_RD : ST_AHI;
                  out_reg <= (op_reg == OP_CUR_READ) ? {8'hFF, len_reg == 7'h01}
                                                     : {addr_reg[15:8], 1'b1};
                  len_reg <= (op_reg == OP_CUR_READ) ? len_reg - 7'h01 : len_reg;
                end
                ST_AHI: begin
                  step_reg <= ST_ALO;
                  out_reg <= {addr_reg[7:0], 1'b1};
                end
                ST_ALO: begin
                  step_reg <= (op_reg == OP_WRITE) ? ST_WR : ST_DEVR;
                  st_reg <= (op_reg == OP_WRITE) ? HS_WAIT : HS_START;
                end
                ST_WR: begin
                  st_reg <= (len_reg == 7'h00) ? HS_STOP : HS_WAIT;
                end
                ST_DEVR: begin
                  step_reg <= ST_RD;
                  out_reg <= {8'hFF, len_reg == 7'h01};
                  len_reg <= len_reg - 7'h01;
                end
                default: begin
                  if (len_reg == 7'h00) begin
                    st_reg <= HS_STOP;
                  end else begin
                    out_reg <= {8'hFF, len_reg == 7'h01};
                    len_reg <= len_reg - 7'h01;
                  end
                end
              endcase
            end
          end
        end
        default: begin
          if (tick) begin
            q_reg <= q_reg + 2'h1;
            case (q_reg)
              2'h0: scl_reg <= 1'b0;
              2'h1: oe_reg <= 1'b1;
              2'h2: scl_reg <= 1'b1;
              default: begin
                oe_reg <= 1'b0;
                st_reg <= HS_IDLE;
                DONE <= 1'b1;
                CMD_READY <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  assign bus.scl         = scl_reg;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = oe_reg;

endmodule

// ---- rtl/i2ee_if.sv ----
// Two-wire bus carrier: clock from the master, open-drain data line
`timescale 1ns/1ps
interface i2ee_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND with pull-up: line is low when any enabled driver drives low
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    output scl,
    input  sda,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

// ---- rtl/i2ee_pkg.sv ----
// Types shared by both ends of the serial memory link
package i2ee_pkg;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_DEV   = 3'b001,
    PH_AHI   = 3'b010,
    PH_ALO   = 3'b011,
    PH_WDATA = 3'b100,
    PH_RDATA = 3'b101,
    PH_SKIP  = 3'b110
  } i2ee_phase_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_START = 3'b001,
    HS_BYTE  = 3'b010,
    HS_WAIT  = 3'b011,
    HS_STOP  = 3'b100
  } i2ee_hstate_t;

  typedef enum logic [2:0] {
    ST_DEV  = 3'b000,
    ST_AHI  = 3'b001,
    ST_ALO  = 3'b010,
    ST_WR   = 3'b011,
    ST_DEVR = 3'b100,
    ST_RD   = 3'b101
  } i2ee_step_t;

  typedef enum logic [1:0] {
    OP_WRITE    = 2'b00,
    OP_SEL_READ = 2'b01,
    OP_CUR_READ = 2'b10
  } i2ee_op_t;

endpackage

// ---- test/i2ee_assertions.sv ----
// Wire-level checks on the device side of the two-wire link
`timescale 1ns/1ps
module i2ee_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic BUSY,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  // ----------------------------------------
  // Bit position tracking
  // ----------------------------------------
  logic       scl_reg;
  logic       sda_reg;
  logic       first_reg;
  logic       rd_reg;
  logic [3:0] bits_reg;
  wire        start = scl & scl_reg & sda_reg & ~sda;
  wire        stop  = scl & scl_reg & ~sda_reg & sda;
  wire        rise  = scl & ~scl_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      scl_reg <= 1'h1;
      sda_reg <= 1'h1;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
    end
  end

  // Counts rises since START so the 9th pulse is known; wraps after it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bits_reg  <= 4'h0;
      first_reg <= 1'h0;
      rd_reg    <= 1'h0;
    end else if (start) begin
      bits_reg  <= 4'h0;
      first_reg <= 1'h1;
    end else if (rise) begin
      bits_reg  <= (bits_reg == 4'h8) ? 4'h0 : bits_reg + 4'h1;
      first_reg <= first_reg & (bits_reg != 4'h8);
      rd_reg    <= (first_reg && bits_reg == 4'h7) ? sda : rd_reg;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  drive_fall_a: assert property ($changed(dev_sda_oe) |-> !scl && !dev_sda_o)
    else $error("device moved its drive outside clock low");
  dev_stable_a: assert property (scl && scl_reg |-> $stable(dev_sda_oe))
    else $error("device changed the data line while clock high");
  write_quiet_a: assert property (rise && bits_reg != 4'h8 && (first_reg || !rd_reg)
    |-> !dev_sda_oe)
    else $error("device drove a bit it should receive");
  read_release_a: assert property (rise && bits_reg == 4'h8 && !first_reg && rd_reg
    |-> !dev_sda_oe)
    else $error("device held the line in a read ninth pulse");
  ack_hold_a: assert property (rise && bits_reg == 4'h8 && dev_sda_oe
    |-> dev_sda_oe [*4])
    else $error("acknowledge not held through the ninth pulse");
  busy_nack_a: assert property (rise && bits_reg == 4'h8 && first_reg && BUSY
    |-> !dev_sda_oe)
    else $error("address acknowledged while programming");
  start_free_a: assert property (start |-> !dev_sda_oe [*8])
    else $error("device drives after a start");
  stop_free_a: assert property (stop |-> ##1 !dev_sda_oe [*8])
    else $error("device drives at a stop");
endmodule

// ---- test/tb.sv ----
// Self-checking bench: host and device joined over the two-wire carrier
`timescale 1ns/1ps
module tb;
  import i2ee_pkg::*;
  logic        clk, rst, wp, busy, cmd_valid, cmd_ready, wr_valid, wr_ready;
  logic        rd_valid, done, nack;
  logic [1:0]  cmd_op;
  logic [2:0]  cmd_dev, strap;
  logic [15:0] cmd_addr, a;
  logic [6:0]  cmd_len;
  logic [7:0]  wr_data, rd_data;
  logic [7:0]  mem [0:32767];
  logic [7:0]  exp_q [$];
  logic [14:0] ptr;
  int          errors, tests_run, seed;

  i2ee_if bus ();
  i2ee_dev #(.WR_CYCLES(200)) u_i2ee_dev (.CLK(clk), .RST(rst), .STRAP_SELECT_BIT0(strap[0]),
    .STRAP_SELECT_BIT1(strap[1]), .STRAP_SELECT_BIT2(strap[2]), .WP(wp), .BUSY(busy),
    .bus(bus));
  i2ee_host u_i2ee_host (.CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_OP(cmd_op), .CMD_DEV(cmd_dev), .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len),
    .WR_DATA(wr_data), .WR_VALID(wr_valid), .WR_READY(wr_ready), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .DONE(done), .NACK(nack), .bus(bus));
  i2ee_assertions u_i2ee_assertions (.CLK(clk), .RST(rst), .BUSY(busy), .scl(bus.scl),
    .sda(bus.sda), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'h1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmd(input logic [1:0] op, input logic [2:0] dv, input logic [15:0] ad,
                     input logic [6:0] n, input logic nk);
    int k;
    k = 0;
    cmd_op = op;
    cmd_dev = dv;
    cmd_addr = ad;
    cmd_len = n;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1) tick();
    tick();
    cmd_valid = 1'h0;
    while (done !== 1'h1 && k < 20000) begin
      tick();
      k++;
    end
    chk(k < 20000, "command did not finish");
    chk(nack === nk, "acknowledge outcome");
  endtask

  task automatic push(input logic [7:0] b);
    wr_data = b;
    wr_valid = 1'h1;
    while (wr_ready !== 1'h1) tick();
    tick();
  endtask

  task automatic wr(input logic [15:0] ad, input logic [6:0] n, input logic nk);
    logic [7:0] d [$];
    int         pre;
    for (int i = 0; i < n; i++) d.push_back(8'($random(seed)));
    pre = (n > 16) ? 16 : n;
    for (int i = 0; i < pre; i++) push(d[i]);
    wr_valid = 1'h0;
    // Buffer must refuse once it holds 16 words
    if (n >= 16) chk(wr_ready === 1'h0, "buffer not full");
    fork
      cmd(OP_WRITE, strap, ad, n, nk);
      if (pre < n) begin
        for (int i = pre; i < n; i++) push(d[i]);
        wr_valid = 1'h0;
      end
    join
    if (!nk) begin
      for (int i = 0; i < n; i++) mem[{ad[14:6], 6'(ad[5:0] + 6'(i))}] = d[i];
      ptr = {ad[14:6], 6'(ad[5:0] + 6'(n))};
    end
  endtask

  task automatic rd(input logic [1:0] op, input logic [15:0] ad, input logic [6:0] n);
    if (op == OP_SEL_READ) ptr = ad[14:0];
    for (int i = 0; i < n; i++) exp_q.push_back(mem[ptr + 15'(i)]);
    ptr = ptr + 15'(n);
    cmd(op, strap, ad, n, 1'h0);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    // Programming starts a few cycles after the stop is seen
    repeat (4) tick();
    while (busy !== 1'h0 && k < 1000) begin
      tick();
      k++;
    end
    chk(busy === 1'h0, "programming did not end");
  endtask

  // ----------------------------------------
  // Stimulus, scoreboard and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rd_valid === 1'h1) begin
      if (exp_q.size() == 0) chk(1'h0, "read byte not expected");
      else chk(rd_data === exp_q.pop_front(), "read byte");
    end
  end

  initial begin
    #(40 * 60000);
    errors++;
    wrap_up();
  end

  initial begin
    seed = 52197;
    {errors, tests_run} = '0;
    {rst, wp, cmd_valid, wr_valid} = 4'h8;
    {cmd_op, cmd_dev, cmd_addr, cmd_len, wr_data} = '0;
    strap = 3'($random(seed));
    for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
    repeat (16) @(posedge clk);
    #1 rst = 1'h0;
    rd(OP_SEL_READ, 16'h0100, 7'h04);
    repeat (4) tick();
    chk(busy === 1'h0, "dummy write programmed");
    a = 16'($random(seed));
    a[5:0] = 6'h3E;
    wr(a, 7'h42, 1'h0);
    repeat (4) tick();
    chk(busy === 1'h1, "programming not started");
    cmd(OP_CUR_READ, strap, 16'h0000, 7'h01, 1'h1);
    wait_idle();
    rd(OP_CUR_READ, 16'h0000, 7'h02);
    rd(OP_SEL_READ, {1'h0, a[14:6], 6'h00}, 7'h40);
    rd(OP_SEL_READ, 16'h7FFF, 7'h03);
    cmd(OP_SEL_READ, strap ^ 3'h5, 16'h0000, 7'h01, 1'h1);
    wp = 1'h1;
    wr(16'h0040, 7'h01, 1'h1);
    repeat (4) tick();
    chk(busy === 1'h0, "protected write programmed");
    wp = 1'h0;
    wr(16'h0041, 7'h01, 1'h0);
    wait_idle();
    rd(OP_SEL_READ, 16'h0040, 7'h02);
    repeat (4) tick();
    chk(exp_q.size() == 0, "read bytes missing");
    wrap_up();
  end
endmodule
